// >>> design/stogt_pkg.sv
// constants and types of the safe torque off gating block
// How it works
// - pwm passes only while both inputs high
// - one input low flags mismatch fault code
// - logic supply over/under voltage forces torque off
// - faulty input circuit forces torque off, code
// - faulty buffer circuit forces torque off, code
// - with brake: drive off within 30 ms
// - without brake: drive off within 5 ms
// - pwm buffer disabled throughout power-on
// - pwm buffer disabled until initialisation done
// - auto-reset needs inputs high, servo off, no fault
// - input returning high clears monitor and ready
// - pwm resumes 400 ms after inputs return high
// - pwm blocked typically 30 ms, max 100 ms
// - torque off removes all gating, motor coasts
// - torque off state and fault shown on keypad
package stogt_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned RESTART_MS = 400;
   localparam int unsigned RESTART_CYC = RESTART_MS * (CLK_HZ / 1000);
   localparam int unsigned MISMATCH_US = 1000;
   localparam int unsigned MISMATCH_CYC = MISMATCH_US * (CLK_HZ / 1000000);
   localparam int unsigned RESP_BRAKE_MS = 30;
   localparam int unsigned RESP_NOBRAKE_MS = 5;
   localparam int unsigned RESP_MAX_MS = 100;
   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_INT_STAT = 8'h08;
   localparam logic [7:0] OFS_INT_MASK = 8'h0C;
   localparam int CTRL_AUTO_BIT = 0;
   localparam int CTRL_FCLR_BIT = 1;
   localparam logic CTRL_AUTO_RST = 1'h1;
   localparam logic [5:0] INT_MASK_RST = 6'h00;
   // status fields
   localparam int ST_STATE_LSB = 0;
   localparam int ST_IN_LSB = 4;
   localparam int ST_FLT_LSB = 8;
   localparam int ST_CODE_LSB = 12;
   // interrupt bits
   localparam int EV_STO = 0;
   localparam int EV_MISMATCH = 1;
   localparam int EV_SUPPLY = 2;
   localparam int EV_INCIRC = 3;
   localparam int EV_BUFFER = 4;
   localparam int EV_RUN = 5;
   localparam int EV_W = 6;
   // fault codes: sub-code of the 150 fault group
   localparam logic [2:0] CODE_NONE = 3'h0;
   localparam logic [2:0] CODE_MISMATCH = 3'h1;
   localparam logic [2:0] CODE_SUPPLY = 3'h2;
   localparam logic [2:0] CODE_INCIRC = 3'h3;
   localparam logic [2:0] CODE_BUFFER = 3'h4;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_POWERUP,
      ST_INIT,
      ST_SAFE,
      ST_WAIT,
      ST_RUN
   } stogt_state_t;
   typedef struct packed {
      logic buffer;
      logic incirc;
      logic supply;
      logic mismatch;
   } stogt_flt_t;
   typedef struct packed {
      logic sto_active;
      logic [2:0] code;
   } stogt_keypad_t;
endpackage

// >>> design/stogt_top.sv
// safe torque off gating with ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
module stogt_top #(
   parameter int PWM_W = 6,
   parameter int unsigned RESTART_CYC = stogt_pkg::RESTART_CYC,
   parameter int unsigned MISMATCH_CYC = stogt_pkg::MISMATCH_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // pins
   input wire logic i_torque_off_input_a,
   input wire logic i_torque_off_input_b,
   input wire logic i_supply_over_under_voltage,
   input wire logic i_input_circuit_fault,
   input wire logic i_buffer_circuit_fault,
   input wire logic i_init_done,
   input wire logic i_servo_on,
   input wire logic [PWM_W-1:0] i_pwm,
   output logic [PWM_W-1:0] o_pwm,
   output logic o_pwm_buf_en_n,
   output logic o_external_monitor_output,
   output logic o_servo_ready,
   output logic o_servo_operation,
   output stogt_pkg::stogt_keypad_t o_keypad,
   output logic o_irq,
   // ahb-lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp
);
   import stogt_pkg::*;

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   localparam int SY_W = 7;
   logic [SY_W-1:0] sync1;
   logic [SY_W-1:0] sync2;
   logic in_a;
   logic in_b;
   logic both_high;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sync1 <= '0;
         sync2 <= '0;
      end else if (i_ce) begin
         sync1 <= {i_servo_on, i_init_done, i_buffer_circuit_fault,
                   i_input_circuit_fault, i_supply_over_under_voltage,
                   i_torque_off_input_b, i_torque_off_input_a};
         sync2 <= sync1;
      end
   end

   assign in_a = sync2[0];
   assign in_b = sync2[1];
   assign both_high = in_a & in_b;

   // ------------------------------------------------------------
   // fault detection and latching
   // ------------------------------------------------------------
   stogt_flt_t flt_src;
   stogt_flt_t flt;
   stogt_flt_t flt_set;
   logic [31:0] mis_cnt;
   logic mis_seen;
   logic fault_clr;
   logic fault_any;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         mis_cnt <= '0;
      end else if (i_ce) begin
         if (!(in_a ^ in_b)) begin
            mis_cnt <= '0;
         end else if (!mis_seen) begin
            mis_cnt <= mis_cnt + 32'h1;
         end
      end
   end

   assign mis_seen = (mis_cnt >= MISMATCH_CYC - 1);

   always_comb begin
      flt_src.mismatch = (in_a ^ in_b) & mis_seen;
      flt_src.supply = sync2[2];
      flt_src.incirc = sync2[3];
      flt_src.buffer = sync2[4];
      flt_set = flt_src & ~flt;
   end

   // set wins over a software clear
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         flt <= '0;
      end else if (i_ce) begin
         flt <= flt_src | (fault_clr ? '0 : flt);
      end
   end

   assign fault_any = |flt;

   function automatic logic [2:0] fault_code(input stogt_flt_t f);
      if (f.supply) begin
         return CODE_SUPPLY;
      end else if (f.incirc) begin
         return CODE_INCIRC;
      end else if (f.buffer) begin
         return CODE_BUFFER;
      end else if (f.mismatch) begin
         return CODE_MISMATCH;
      end
      return CODE_NONE;
   endfunction

   // ------------------------------------------------------------
   // safe state sequencer
   // ------------------------------------------------------------
   stogt_state_t state;
   stogt_state_t next_state;
   logic [31:0] rst_cnt;
   logic auto_en;

   always_comb begin
      next_state = state;
      case (state)
         ST_POWERUP: begin
            next_state = ST_INIT;
         end
         ST_INIT: begin
            if (sync2[5]) begin
               next_state = ST_SAFE;
            end
         end
         ST_SAFE: begin
            if (auto_en && both_high && !sync2[6] && !fault_any) begin
               next_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (!both_high || fault_any) begin
               next_state = ST_SAFE;
            end else if (rst_cnt >= RESTART_CYC - 1) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!both_high || fault_any) begin
               next_state = ST_SAFE;
            end
         end
         default: begin
            next_state = ST_SAFE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state <= ST_POWERUP;
      end else if (i_ce) begin
         state <= next_state;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rst_cnt <= '0;
      end else if (i_ce) begin
         if (state == ST_WAIT && next_state == ST_WAIT) begin
            rst_cnt <= rst_cnt + 32'h1;
         end else begin
            rst_cnt <= '0;
         end
      end
   end

   // ------------------------------------------------------------
   // gated outputs
   // ------------------------------------------------------------
   logic pass;

   // combinational gate needs the run state as well as synced inputs high and no fault
   assign pass = (state == ST_RUN) && both_high && !fault_any;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_pwm <= '0;
         o_pwm_buf_en_n <= 1'b1;
      end else if (i_ce) begin
         o_pwm <= pass ? i_pwm : '0;
         o_pwm_buf_en_n <= !pass;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_external_monitor_output <= 1'b0;
         o_servo_ready <= 1'b0;
         o_servo_operation <= 1'b0;
      end else if (i_ce) begin
         o_external_monitor_output <= (state == ST_SAFE) && !in_a && !in_b;
         o_servo_ready <= (next_state == ST_RUN);
         o_servo_operation <= pass;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_keypad <= '{sto_active: 1'b1, code: CODE_NONE};
      end else if (i_ce) begin
         o_keypad.sto_active <= (next_state != ST_RUN);
         o_keypad.code <= fault_code(flt);
      end
   end

   // ------------------------------------------------------------
   // interrupt events
   // ------------------------------------------------------------
   logic [EV_W-1:0] ev;
   logic [EV_W-1:0] int_stat;
   logic [EV_W-1:0] int_mask;
   logic [EV_W-1:0] w1c;

   always_comb begin
      ev = '0;
      ev[EV_STO] = (next_state == ST_SAFE) && (state != ST_SAFE);
      ev[EV_MISMATCH] = flt_set.mismatch;
      ev[EV_SUPPLY] = flt_set.supply;
      ev[EV_INCIRC] = flt_set.incirc;
      ev[EV_BUFFER] = flt_set.buffer;
      ev[EV_RUN] = (next_state == ST_RUN) && (state != ST_RUN);
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         int_stat <= '0;
      end else if (i_ce) begin
         int_stat <= ev | (int_stat & ~w1c);
      end
   end

   assign o_irq = |(int_stat & int_mask);

   // ------------------------------------------------------------
   // ahb-lite slave
   // ------------------------------------------------------------
   logic dp_wr;
   logic [7:0] dp_addr;
   logic [31:0] rd_val;
   logic wr_ctrl;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         dp_wr <= 1'b0;
         dp_addr <= '0;
      end else if (i_ce) begin
         dp_wr <= i_hsel && i_htrans[1] && i_hready && i_hwrite;
         dp_addr <= i_haddr[7:0];
      end
   end

   assign wr_ctrl = dp_wr && (dp_addr == OFS_CTRL);
   assign fault_clr = wr_ctrl && i_hwdata[CTRL_FCLR_BIT];
   assign w1c = (dp_wr && dp_addr == OFS_INT_STAT) ?
                i_hwdata[EV_W-1:0] : '0;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         auto_en <= CTRL_AUTO_RST;
         int_mask <= INT_MASK_RST;
      end else if (i_ce) begin
         if (wr_ctrl) begin
            auto_en <= i_hwdata[CTRL_AUTO_BIT];
         end
         if (dp_wr && dp_addr == OFS_INT_MASK) begin
            int_mask <= i_hwdata[EV_W-1:0];
         end
      end
   end

   always_comb begin
      rd_val = '0;
      case (i_haddr[7:0])
         OFS_CTRL: begin
            rd_val[CTRL_AUTO_BIT] = auto_en;
         end
         OFS_STATUS: begin
            rd_val[ST_STATE_LSB +: 3] = state;
            rd_val[ST_IN_LSB +: 2] = {in_b, in_a};
            rd_val[ST_FLT_LSB +: 4] = flt;
            rd_val[ST_CODE_LSB +: 3] = fault_code(flt);
         end
         OFS_INT_STAT: begin
            rd_val[EV_W-1:0] = int_stat;
         end
         OFS_INT_MASK: begin
            rd_val[EV_W-1:0] = int_mask;
         end
         default: begin
            rd_val = '0;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_hrdata <= '0;
      end else if (i_ce) begin
         if (i_hsel && i_htrans[1] && i_hready && !i_hwrite) begin
            o_hrdata <= rd_val;
         end
      end
   end

   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;

endmodule // stogt_top
`default_nettype wire

// >>> dv/stogt_checker.sv
// concurrent checks on the safe torque off gating ports
`timescale 1ns/1ps
`default_nettype none
module stogt_checker #(
   parameter int PWM_W = 6,
   parameter int unsigned RESTART_CYC = 20,
   parameter int unsigned MISMATCH_CYC = 4
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_torque_off_input_a,
   input wire logic i_torque_off_input_b,
   input wire logic i_supply_over_under_voltage,
   input wire logic i_input_circuit_fault,
   input wire logic i_buffer_circuit_fault,
   input wire logic i_init_done,
   input wire logic [PWM_W-1:0] o_pwm,
   input wire logic o_pwm_buf_en_n,
   input wire logic o_external_monitor_output,
   input wire logic o_servo_ready,
   input wire logic o_servo_operation,
   input wire stogt_pkg::stogt_keypad_t o_keypad
);
   import stogt_pkg::*;
   logic both;
   logic [31:0] hi_cnt;
   assign both = i_torque_off_input_a && i_torque_off_input_b;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   // cycles both inputs have stayed high
   always_ff @(posedge i_clk) begin
      if (i_rst || !both) begin
         hi_cnt <= 32'h0;
      end else if (hi_cnt != 32'hFFFFFFFF) begin
         hi_cnt <= hi_cnt + 32'h1;
      end
   end
   sequence s_off;
      o_pwm == '0 && o_pwm_buf_en_n && !o_servo_operation;
   endsequence
   sequence s_clear;
      !o_external_monitor_output && !o_servo_ready;
   endsequence
   a_gate_both: assert property (!both |-> ##[1:3] s_off)
      else $error("pwm not gated after input drop");
   a_resp_fast: assert property ($fell(i_torque_off_input_a) |->
      ##[1:3] !o_servo_ready) else $error("drive not disabled in time");
   a_run_hold: assert property ($rose(o_servo_operation) |->
      hi_cnt >= RESTART_CYC) else $error("pwm resumed too early");
   a_mismatch_code: assert property (
      (i_torque_off_input_a ^ i_torque_off_input_b) [*8] |->
      ##[0:3] o_keypad.code != CODE_NONE) else $error("mismatch not shown");
   a_supply_off: assert property (i_supply_over_under_voltage [*3] |->
      ##[0:4] (o_pwm_buf_en_n && o_keypad.code == CODE_SUPPLY))
      else $error("supply fault not handled");
   a_circuit_off: assert property (
      (i_input_circuit_fault || i_buffer_circuit_fault) [*3] |->
      ##[0:4] s_off) else $error("circuit fault not handled");
   a_init_hold: assert property (!i_init_done [*3] |->
      o_pwm_buf_en_n) else $error("buffer enabled before init");
   a_monitor_clear: assert property (
      $rose(i_torque_off_input_a || i_torque_off_input_b) |->
      ##3 s_clear [*2]) else $error("monitor or ready not cleared");
   a_run_clean: assert property (o_servo_ready |->
      !o_keypad.sto_active && o_keypad.code == CODE_NONE)
      else $error("run with fault shown");
endmodule // stogt_checker
bind stogt_top stogt_checker #(.PWM_W(PWM_W), .RESTART_CYC(RESTART_CYC),
   .MISMATCH_CYC(MISMATCH_CYC)) i_chk (.i_clk, .i_rst,
   .i_torque_off_input_a, .i_torque_off_input_b,
   .i_supply_over_under_voltage, .i_input_circuit_fault,
   .i_buffer_circuit_fault, .i_init_done, .o_pwm, .o_pwm_buf_en_n,
   .o_external_monitor_output, .o_servo_ready, .o_servo_operation,
   .o_keypad);
`default_nettype wire

// >>> dv/stogt_relay.sv
// safety relay model driving both torque off channels
`timescale 1ns/1ps
`default_nettype none
module stogt_relay (
   input wire logic i_clk,
   input wire logic i_open_a,
   input wire logic i_open_b,
   input wire logic i_lag,
   output logic o_ch_a,
   output logic o_ch_b
);
   logic lag_b;
   // channel b may trail a by one cycle, as real contacts do
   always_ff @(posedge i_clk) begin
      lag_b <= i_open_b;
   end
   assign o_ch_a = !i_open_a;
   assign o_ch_b = !(i_lag ? lag_b : i_open_b);
endmodule // stogt_relay
`default_nettype wire

// >>> dv/test_safe_torque_off_gating.sv
// self-checking bench of the safe torque off gating block
`timescale 1ns/1ps
`default_nettype none
module test_safe_torque_off_gating;
   import stogt_pkg::*;
   localparam int RC = 20;
   localparam logic [5:0] PAT = 6'h2D;
   logic clk = 1'b0, rst = 1'b1, lag = 1'b0, hsel = 1'b0, hwr = 1'b0;
   logic open_a = 1'b0, open_b = 1'b0, init = 1'b0, son = 1'b0;
   logic ch_a, ch_b, en_n, mon, rdy, op, irq, hrdy, hresp;
   logic [2:0] flt = 3'h0;
   logic [1:0] htr = 2'h0;
   logic [31:0] hadr = 32'h0, hwd = 32'h0, hrd, q;
   logic [5:0] opwm;
   stogt_keypad_t kp;
   int n_fail = 0, cmp_count = 0;
   always #12.5 clk = ~clk;
   stogt_relay i_rly (.i_clk(clk), .i_open_a(open_a), .i_open_b(open_b),
      .i_lag(lag), .o_ch_a(ch_a), .o_ch_b(ch_b));
   stogt_top #(.RESTART_CYC(RC), .MISMATCH_CYC(4)) i_dut (.i_clk(clk),
      .i_rst(rst), .i_ce(1'b1), .i_torque_off_input_a(ch_a),
      .i_torque_off_input_b(ch_b), .i_supply_over_under_voltage(flt[0]),
      .i_input_circuit_fault(flt[1]), .i_buffer_circuit_fault(flt[2]),
      .i_init_done(init), .i_servo_on(son), .i_pwm(PAT), .o_pwm(opwm),
      .o_pwm_buf_en_n(en_n), .o_external_monitor_output(mon),
      .o_servo_ready(rdy), .o_servo_operation(op), .o_keypad(kp),
      .o_irq(irq), .i_hsel(hsel), .i_haddr(hadr), .i_htrans(htr),
      .i_hwrite(hwr), .i_hsize(3'h2), .i_hwdata(hwd), .i_hready(hrdy),
      .o_hrdata(hrd), .o_hreadyout(hrdy), .o_hresp(hresp));
   task automatic tally_and_finish();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic rdy_wait();
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hrdy !== 1'b1 && k < 50);
      if (hrdy !== 1'b1) begin
         n_fail++;
         tally_and_finish();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      hsel <= 1'b1;
      htr <= 2'h2;
      hwr <= w;
      hadr <= {24'h0, a};
      rdy_wait();
      hsel <= 1'b0;
      htr <= 2'h0;
      hwd <= d;
      rdy_wait();
      q = hrd;
   endtask
   task automatic wait_run();
      int k;
      k = 0;
      while (op !== 1'b1 && k < 60) begin
         @(posedge clk);
         k++;
      end
      if (op !== 1'b1) begin
         n_fail++;
         tally_and_finish();
      end
      cyc(2);
      chk(opwm, PAT);
      chk({rdy, en_n}, 2'h2);
   endtask
   task automatic t_init();
      cyc(8);
      chk({mon, rdy, op, en_n}, 4'h1);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(q[5:0], 6'h31);
      chk({hresp, hrdy}, 2'h1);
      bus(1'b0, OFS_CTRL, 32'h0);
      chk(q, 32'h1);
      bus(1'b0, OFS_INT_MASK, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, 8'h10, 32'h0);
      chk(q, 32'h0);
      init <= 1'b1;
      wait_run();
   endtask
   task automatic t_restart();
      open_a <= 1'b1;
      open_b <= 1'b1;
      cyc(4);
      chk({opwm, en_n, op}, {6'h0, 2'h2});
      cyc(4);
      chk({mon, kp}, {2'h3, CODE_NONE});
      open_a <= 1'b0;
      open_b <= 1'b0;
      cyc(5);
      chk({mon, rdy}, 2'h0);
      cyc(RC - 5);
      chk(op, 1'b0);
      wait_run();
   endtask
   task automatic t_mismatch();
      open_a <= 1'b1;
      cyc(14);
      chk({en_n, kp.code, irq}, {1'b1, CODE_MISMATCH, 1'b0});
      bus(1'b1, OFS_INT_MASK, 32'h2);
      cyc(1);
      chk(irq, 1'b1);
      open_a <= 1'b0;
      cyc(40);
      chk(op, 1'b0);
      bus(1'b1, OFS_CTRL, 32'h3);
      bus(1'b1, OFS_INT_STAT, 32'h3F);
      cyc(1);
      chk(irq, 1'b0);
      wait_run();
      bus(1'b1, OFS_INT_MASK, 32'h0);
   endtask
   task automatic t_servo();
      open_a <= 1'b1;
      open_b <= 1'b1;
      son <= 1'b1;
      cyc(6);
      open_a <= 1'b0;
      open_b <= 1'b0;
      cyc(40);
      chk(op, 1'b0);
      bus(1'b1, OFS_CTRL, 32'h0);
      son <= 1'b0;
      cyc(40);
      chk(op, 1'b0);
      bus(1'b0, OFS_CTRL, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, OFS_CTRL, 32'h1);
      wait_run();
   endtask
   task automatic t_lag();
      lag <= 1'b1;
      open_a <= 1'b1;
      open_b <= 1'b1;
      cyc(10);
      open_a <= 1'b0;
      open_b <= 1'b0;
      cyc(10);
      chk(kp.code, CODE_NONE);
      lag <= 1'b0;
      wait_run();
   endtask
   task automatic t_faults();
      for (int i = 0; i < 3; i++) begin
         flt[i] <= 1'b1;
         cyc(8);
         chk({en_n, op, kp}, {3'h5, CODE_SUPPLY + 3'(i)});
         flt[i] <= 1'b0;
         bus(1'b0, OFS_STATUS, 32'h0);
         chk(q[11:8], 4'h2 << i);
         bus(1'b1, OFS_CTRL, 32'h3);
         bus(1'b0, OFS_INT_STAT, 32'h0);
         chk(q[EV_SUPPLY + i], 1'b1);
         bus(1'b1, OFS_INT_STAT, 32'h3F);
         wait_run();
      end
   endtask
   initial begin
      cyc(16);
      rst <= 1'b0;
      t_init();
      t_restart();
      t_mismatch();
      t_servo();
      t_lag();
      t_faults();
      tally_and_finish();
   end
endmodule // test_safe_torque_off_gating
`default_nettype wire
